// *** rtl/usr_special_regs.sv ***
// Operation
// - sticky error set by range error, software clears
// - range error is carry0 xor carry1 when enabled
// - compares and ops without overflow enable keep range error
// - carrying and extended ops set wrap from carry0
// - others keep wrap; shift-algebraic sets on ones lost from a negative operand
// - flags come from whole three-operand sum
// - bits 8..15 stored; other reserved read zero
// - seven-bit field gives string byte count
// - branch-to-link target comes from link register
// - low link bits stored, masked for fetch
// - link option writes next address, taken or not
// - counted branch decrements count, zero wraps
// - branch-to-count target comes from count register
// - 64-bit time counter increments on ticks
// - time counter readable as high, low halves
// - user reads at 268/269, supervisor-only writes
// - halves read separately, no 64-bit read
`timescale 1ns/1ps
`default_nettype none
module usr_special_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // completed operations from execution units
  input wire usr_pkg::usr_alu_op_t aluOp,
  input wire usr_pkg::usr_branch_t branch,
  // special register move port
  input wire usr_pkg::usr_spr_req_t sprReq,
  output logic [31:0] sprRdData,
  output logic sprRdValid,
  output logic sprErr,
  // periodic tick from outside the core clock
  input wire logic timeTickPin,
  // values the core consumes
  output logic [31:0] linkFetchAddr,
  output logic [31:0] countTarget,
  output logic [6:0] stringByteCount,
  output logic stickyErr,
  output logic unsignedWrap
);
  import usr_pkg::*;

  // ==========================================================
  // exception flags
  // ==========================================================
  logic sticky_r, sticky_nxt;  // sticky error
  logic rangeErr_r, rangeErr_nxt;  // signed range error
  logic wrap_r, wrap_nxt;  // unsigned wrap
  logic [USR_KEEP_W-1:0] keep_r, keep_nxt;  // write-and-keep reserved bits
  logic [USR_BYTES_W-1:0] bytes_r, bytes_nxt;  // string byte count
  logic [31:0] opX, opY;  // sum operands after inversion
  logic opCin;  // carry into bit 0
  logic [32:0] opSum;  // full sum with carry out
  logic carryMsb, carryNext;  // carry out of msb and of next bit
  logic [31:0] shMask;  // bits shifted out by the algebraic shift
  logic sraLost;  // negative operand lost a one
  logic arithOp, carryOp;  // operation classes
  logic mtFlags;  // software write to flags
  logic [31:0] flagsWord;  // flags as read

  assign mtFlags = sprReq.mtValid && sprReq.sprNum == USR_SPR_FLAGS;
  assign flagsWord = {sticky_r, rangeErr_r, wrap_r, 13'h0000, keep_r, 1'b0, bytes_r};

  // whole-operation sum, never a partial one
  always_comb
  begin
    opX = aluOp.a;
    opY = aluOp.b;
    opCin = 1'b0;
    case (aluOp.kind)
      USR_OP_ADDE: opCin = wrap_r;
      USR_OP_SUBF, USR_OP_SUBFC:
      begin
        opX = ~aluOp.a;  // subtract-from is ~a + b + 1
        opCin = 1'b1;
      end
      USR_OP_SUBFE:
      begin
        opX = ~aluOp.a;
        opCin = wrap_r;
      end
      default: opCin = 1'b0;
    endcase
    opSum = {1'b0, opX} + {1'b0, opY} + {32'h00000000, opCin};
    carryMsb = opSum[32];
    carryNext = opSum[31] ^ opX[31] ^ opY[31];  // carry into the msb
    shMask = ~(32'hffffffff << aluOp.shamt);  // shifts of 32 or more lose all
    sraLost = aluOp.a[31] && |(aluOp.a & shMask);
    arithOp = aluOp.kind inside {USR_OP_ADD, USR_OP_ADDC, USR_OP_ADDE,
                                 USR_OP_SUBF, USR_OP_SUBFC, USR_OP_SUBFE};
    carryOp = aluOp.kind inside {USR_OP_ADDC, USR_OP_ADDE, USR_OP_SUBFC, USR_OP_SUBFE};
  end

  // flag next values; hardware updates land after software writes so a set is never lost
  always_comb
  begin
    sticky_nxt = sticky_r;
    rangeErr_nxt = rangeErr_r;
    wrap_nxt = wrap_r;
    keep_nxt = keep_r;
    bytes_nxt = bytes_r;
    if (mtFlags)
    begin
      sticky_nxt = sprReq.wdata[USR_SO_BIT];  // only software clears it
      rangeErr_nxt = sprReq.wdata[USR_RANGE_BIT];
      wrap_nxt = sprReq.wdata[USR_WRAP_BIT];
      keep_nxt = sprReq.wdata[USR_KEEP_LSB +: USR_KEEP_W];
      bytes_nxt = sprReq.wdata[USR_BYTES_LSB +: USR_BYTES_W];
    end
    if (aluOp.valid)
    begin
      // compares and flagless ops fall through untouched
      if (arithOp && aluOp.oe)
      begin
        rangeErr_nxt = carryMsb ^ carryNext;
        if (carryMsb ^ carryNext)
          sticky_nxt = 1'b1;
      end
      if (carryOp)
        wrap_nxt = carryMsb;
      else if (aluOp.kind == USR_OP_SRA)
        wrap_nxt = sraLost;
    end
  end

  // contents are not reset on purpose
  always_ff @(posedge clk)
  begin
    sticky_r <= sticky_nxt;
    rangeErr_r <= rangeErr_nxt;
    wrap_r <= wrap_nxt;
    keep_r <= keep_nxt;
    bytes_r <= bytes_nxt;
  end

  assign stickyErr = sticky_r;
  assign unsignedWrap = wrap_r;
  assign stringByteCount = bytes_r;

  // ==========================================================
  // link target and loop count
  // ==========================================================
  logic [31:0] link_r, link_nxt;  // link register, all bits kept
  logic [31:0] linkFetch_r, linkFetch_nxt;  // fetch copy with low bits cleared
  logic [31:0] count_r, count_nxt;  // loop count
  logic mtLink, mtCount;  // software writes

  assign mtLink = sprReq.mtValid && sprReq.sprNum == USR_SPR_LINK;
  assign mtCount = sprReq.mtValid && sprReq.sprNum == USR_SPR_COUNT;

  // branch updates win over a move in the same cycle
  always_comb
  begin
    link_nxt = link_r;
    count_nxt = count_r;
    if (mtLink)
      link_nxt = sprReq.wdata;
    if (mtCount)
      count_nxt = sprReq.wdata;
    if (branch.valid && branch.link)
      link_nxt = branch.nextPc;
    if (branch.valid && branch.decCount)
      count_nxt = count_r - 32'h00000001;
    // a separate copy keeps the fetch output a plain flop
    linkFetch_nxt = {link_nxt[31:2], 2'b00};
  end

  // contents are not reset on purpose
  always_ff @(posedge clk)
  begin
    link_r <= link_nxt;
    linkFetch_r <= linkFetch_nxt;
    count_r <= count_nxt;
  end

  assign linkFetchAddr = linkFetch_r;
  assign countTarget = count_r;

  // ==========================================================
  // time counter
  // ==========================================================
  logic tickMeta_r, tickSync_r, tickLast_r;  // tick synchroniser and edge history
  logic tickMeta_nxt, tickSync_nxt, tickLast_nxt;
  logic tickEdge;  // one core cycle per tick
  logic [63:0] timeCnt_r, timeCnt_nxt;  // counter, high half in bits 63:32
  logic wrLow, wrHigh;  // supervisor writes

  assign tickEdge = tickSync_r && !tickLast_r;
  assign wrLow = sprReq.mtValid && sprReq.supervisor && sprReq.sprNum == USR_SPR_TLO_WR;
  assign wrHigh = sprReq.mtValid && sprReq.supervisor && sprReq.sprNum == USR_SPR_THI_WR;

  // increment then let a supervisor write replace its half
  always_comb
  begin
    tickMeta_nxt = timeTickPin;
    tickSync_nxt = tickMeta_r;
    tickLast_nxt = tickSync_r;
    timeCnt_nxt = timeCnt_r + {63'h0, tickEdge};
    if (wrLow)
      timeCnt_nxt[31:0] = sprReq.wdata;
    if (wrHigh)
      timeCnt_nxt[63:32] = sprReq.wdata;
  end

  // synchroniser resets; counter contents do not
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tickMeta_r <= 1'b0;
      tickSync_r <= 1'b0;
      tickLast_r <= 1'b0;
    end
    else
    begin
      tickMeta_r <= tickMeta_nxt;
      tickSync_r <= tickSync_nxt;
      tickLast_r <= tickLast_nxt;
    end
    timeCnt_r <= timeCnt_nxt;
  end

  // ==========================================================
  // move answers
  // ==========================================================
  logic [31:0] rdData_r, rdData_nxt;  // read data
  logic rdValid_r, rdValid_nxt;  // read answer strobe
  logic err_r, err_nxt;  // refused move strobe

  // decode; a half is read alone, a 64-bit read does not exist
  always_comb
  begin
    rdData_nxt = 32'h00000000;
    rdValid_nxt = 1'b0;
    err_nxt = 1'b0;
    if (sprReq.mfValid)
    begin
      rdValid_nxt = 1'b1;
      if (sprReq.sprNum == USR_SPR_FLAGS)
        rdData_nxt = flagsWord;
      else if (sprReq.sprNum == USR_SPR_LINK)
        rdData_nxt = link_r;
      else if (sprReq.sprNum == USR_SPR_COUNT)
        rdData_nxt = count_r;
      else if (sprReq.sprNum == USR_SPR_TLO_RD)
        rdData_nxt = timeCnt_r[31:0];
      else if (sprReq.sprNum == USR_SPR_THI_RD)
        rdData_nxt = timeCnt_r[63:32];
      else
        err_nxt = 1'b1;  // unmapped, answers zero
    end
    else if (sprReq.mtValid)
    begin
      // user writes to the counter and writes to read encodings are dropped
      if (!(mtFlags || mtLink || mtCount || wrLow || wrHigh))
        err_nxt = 1'b1;
    end
  end

  // answer strobes reset to idle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdData_r <= 32'h00000000;
      rdValid_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      err_r <= err_nxt;
    end
  end

  assign sprRdData = rdData_r;
  assign sprRdValid = rdValid_r;
  assign sprErr = err_r;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_sticky_holds;
    sticky_r && !mtFlags |=> sticky_r;
  endproperty
  a_sticky_holds: assert property (p_sticky_holds) else $error("sticky error dropped");
  property p_range_sets;
    aluOp.valid && arithOp && aluOp.oe && (carryMsb ^ carryNext) |=> rangeErr_r && sticky_r;
  endproperty
  a_range_sets: assert property (p_range_sets) else $error("range error not raised");
  property p_cmp_keeps;
    aluOp.valid && aluOp.kind == USR_OP_CMP && !mtFlags |=> $stable(rangeErr_r) && $stable(wrap_r);
  endproperty
  a_cmp_keeps: assert property (p_cmp_keeps) else $error("compare changed flags");
  property p_carry_out;
    aluOp.valid && carryOp |=> wrap_r == $past(opSum[32]);
  endproperty
  a_carry_out: assert property (p_carry_out) else $error("wrap flag wrong");
  property p_sra_lost;
    aluOp.valid && aluOp.kind == USR_OP_SRA |=> wrap_r == $past(sraLost);
  endproperty
  a_sra_lost: assert property (p_sra_lost) else $error("shift wrap flag wrong");
  property p_reserved_zero;
    sprReq.mfValid && sprReq.sprNum == USR_SPR_FLAGS |=>
      sprRdData[28:16] == 13'h0000 && !sprRdData[7];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");
  property p_link_write;
    branch.valid && branch.link |=> link_r == $past(branch.nextPc) &&
      linkFetchAddr == {$past(branch.nextPc[31:2]), 2'b00};
  endproperty
  a_link_write: assert property (p_link_write) else $error("link not written");
  property p_count_dec;
    branch.valid && branch.decCount |=> count_r == $past(count_r) - 32'h00000001;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented");
  property p_tick_inc;
    tickEdge && !wrLow && !wrHigh |=> timeCnt_r == $past(timeCnt_r) + 64'h0000000000000001;
  endproperty
  a_tick_inc: assert property (p_tick_inc) else $error("time counter missed tick");
  property p_low_read;
    sprReq.mfValid && sprReq.sprNum == USR_SPR_TLO_RD |=>
      sprRdValid && sprRdData == $past(timeCnt_r[31:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low half read wrong");
  property p_user_no_write;
    sprReq.mtValid && !sprReq.supervisor && !tickEdge |=> $stable(timeCnt_r);
  endproperty
  a_user_no_write: assert property (p_user_no_write) else $error("user wrote counter");
endmodule : usr_special_regs
`default_nettype wire

// *** common/usr_pkg.sv ***
// ==========================================================
// user special register constants and carriers
// ==========================================================
package usr_pkg;
  localparam int unsigned USR_WORD_W = 32;  // register width
  localparam int unsigned USR_TIME_W = 64;  // time counter width
  localparam int unsigned USR_SPR_W = 10;  // special register number width
  localparam int unsigned USR_BYTES_W = 7;  // string byte count width
  localparam int unsigned USR_KEEP_W = 8;  // write-and-keep reserved field width
  // special register numbers
  localparam logic [9:0] USR_SPR_FLAGS = 10'h001;  // exception flags
  localparam logic [9:0] USR_SPR_LINK = 10'h008;  // link target
  localparam logic [9:0] USR_SPR_COUNT = 10'h009;  // loop count
  localparam logic [9:0] USR_SPR_TLO_RD = 10'h10c;  // low half, read
  localparam logic [9:0] USR_SPR_THI_RD = 10'h10d;  // high half, read
  localparam logic [9:0] USR_SPR_TLO_WR = 10'h11c;  // low half, supervisor write
  localparam logic [9:0] USR_SPR_THI_WR = 10'h11d;  // high half, supervisor write
  // flag positions in the 32-bit word (lsb numbering)
  localparam int unsigned USR_SO_BIT = 31;  // sticky error
  localparam int unsigned USR_RANGE_BIT = 30;  // signed range error
  localparam int unsigned USR_WRAP_BIT = 29;  // unsigned wrap
  localparam int unsigned USR_KEEP_LSB = 8;  // kept reserved field low bit
  localparam int unsigned USR_BYTES_LSB = 0;  // byte count low bit
  // operation kinds reported by the integer unit
  typedef enum logic [3:0] {
    USR_OP_NOFLAG, USR_OP_ADD, USR_OP_ADDC, USR_OP_ADDE,
    USR_OP_SUBF, USR_OP_SUBFC, USR_OP_SUBFE, USR_OP_SRA, USR_OP_CMP
  } usr_op_kind_t;
  // completed integer operation
  typedef struct packed {
    logic valid;
    usr_op_kind_t kind;
    logic oe;
    logic [31:0] a;
    logic [31:0] b;
    logic [5:0] shamt;
  } usr_alu_op_t;
  // completed branch
  typedef struct packed {
    logic valid;
    logic link;
    logic decCount;
    logic [31:0] nextPc;
  } usr_branch_t;
  // special register move request
  typedef struct packed {
    logic mfValid;
    logic mtValid;
    logic supervisor;
    logic [9:0] sprNum;
    logic [31:0] wdata;
  } usr_spr_req_t;
endpackage : usr_pkg

// *** verif/usr_exec_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// execution units and tick source
// ==========================================
module usr_exec_model (
  // core clock
  input wire logic clk,
  // completed work toward the registers
  output var usr_pkg::usr_alu_op_t aluOp,
  output var usr_pkg::usr_branch_t branch,
  // periodic tick pin
  output logic timeTickPin
);
  import usr_pkg::*;
  // idle at time zero, nothing in flight
  initial
  begin
    aluOp = '0;
    branch = '0;
    timeTickPin = 1'h0;
  end
  // one completed integer op, a single-cycle pulse
  task automatic alu(input usr_op_kind_t kind, input logic oe, input logic [31:0] a,
    input logic [31:0] b, input logic [5:0] sh);
    @(negedge clk);
    aluOp = '{1'h1, kind, oe, a, b, sh};
    @(negedge clk);
    aluOp = '0;
  endtask : alu
  // one completed branch
  task automatic br(input logic link, input logic dec, input logic [31:0] pc);
    @(negedge clk);
    branch = '{1'h1, link, dec, pc};
    @(negedge clk);
    branch = '0;
  endtask : br
  // one tick; high and low held 3 clocks so the synchroniser sees each level
  task automatic tick();
    @(negedge clk);
    timeTickPin = 1'h1;
    repeat (3) @(negedge clk);
    timeTickPin = 1'h0;
    repeat (3) @(negedge clk);
  endtask : tick
endmodule : usr_exec_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// special register bench
// ==========================================
module testbench;
  import usr_pkg::*;
  logic clk; // 200 MHz core clock
  logic reset; // synchronous, active high
  usr_spr_req_t sprReq; // move requests
  usr_alu_op_t aluOp;
  usr_branch_t branch;
  logic timeTickPin;
  logic [31:0] sprRdData;
  logic [31:0] linkFetchAddr;
  logic [31:0] countTarget;
  logic [6:0] stringByteCount;
  logic sprRdValid;
  logic sprErr;
  logic stickyErr;
  logic unsignedWrap;
  int failCount; // mismatches
  int testsRun; // comparisons made
  usr_special_regs u_dut (
    .clk(clk), .reset(reset), .aluOp(aluOp), .branch(branch), .sprReq(sprReq),
    .sprRdData(sprRdData), .sprRdValid(sprRdValid), .sprErr(sprErr),
    .timeTickPin(timeTickPin), .linkFetchAddr(linkFetchAddr), .countTarget(countTarget),
    .stringByteCount(stringByteCount), .stickyErr(stickyErr), .unsignedWrap(unsignedWrap)
  );
  usr_exec_model u_exec (
    .clk(clk), .aluOp(aluOp), .branch(branch), .timeTickPin(timeTickPin)
  );
  // ==========================================
  // clock
  // ==========================================
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // shared tasks
  // ==========================================
  // case equality so an unknown never counts as a match
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // read move; answer stands only in the cycle after the request
  task automatic rd(input logic [9:0] num, input logic [31:0] exp, input logic err);
    @(negedge clk);
    sprReq = '{1'h1, 1'h0, 1'h0, num, 32'h0};
    @(negedge clk);
    check("read", {sprRdValid, sprErr, sprRdData}, {1'h1, err, exp});
    sprReq = '0;
  endtask : rd
  // write move; a refusal shows as one error pulse
  task automatic wr(input logic [9:0] num, input logic [31:0] d, input logic sup,
    input logic err);
    @(negedge clk);
    sprReq = '{1'h0, 1'h1, sup, num, d};
    @(negedge clk);
    check("write", {sprRdValid, sprErr, sprRdData}, {1'h0, err, 32'h0});
    sprReq = '0;
  endtask : wr
  // integer op, then the three flags over a byte count of 0x25
  task automatic op(input usr_op_kind_t k, input logic oe, input logic [31:0] a,
    input logic [31:0] b, input logic [5:0] sh, input logic [2:0] f);
    u_exec.alu(k, oe, a, b, sh);
    rd(USR_SPR_FLAGS, {f, 29'h25}, 1'h0);
    check("wrap pin", {33'h0, unsignedWrap}, {33'h0, f[0]});
    check("sticky pin", {33'h0, stickyErr}, {33'h0, f[2]});
  endtask : op
  // ==========================================
  // watchdog, far beyond the under two hundred cycles needed
  // ==========================================
  initial
  begin
    #20000;
    failCount++;
    close_out();
  end
  // ==========================================
  // main sequence
  // ==========================================
  initial
  begin
    reset = 1'h1;
    sprReq = '0;
    failCount = 0;
    testsRun = 0;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    // counter has no reset value; load it so user-move checks never see unknowns
    wr(USR_SPR_TLO_WR, 32'h0, 1'h1, 1'h0);
    wr(USR_SPR_THI_WR, 32'h0, 1'h1, 1'h0);
    // flags word: kept reserved field stored, other reserved bits read zero
    wr(USR_SPR_FLAGS, 32'hffffffff, 1'h0, 1'h0);
    rd(USR_SPR_FLAGS, 32'he000ff7f, 1'h0);
    check("byte count", {27'h0, stringByteCount}, 34'h7f);
    wr(USR_SPR_FLAGS, 32'h00000025, 1'h0, 1'h0);
    check("byte count", {27'h0, stringByteCount}, 34'h25);
    check("sticky clear", {33'h0, stickyErr}, 34'h0);
    // flag updates, awkward cases of each op kind but SUBF and NOFLAG
    op(USR_OP_ADD, 1'h1, 32'h7fffffff, 32'h1, 6'h0, 3'h6);
    op(USR_OP_ADD, 1'h1, 32'h1, 32'h1, 6'h0, 3'h4);
    op(USR_OP_ADDC, 1'h0, 32'hffffffff, 32'h1, 6'h0, 3'h5);
    op(USR_OP_CMP, 1'h1, 32'h7fffffff, 32'h1, 6'h0, 3'h5);
    op(USR_OP_ADD, 1'h0, 32'h7fffffff, 32'h1, 6'h0, 3'h5);
    op(USR_OP_ADDE, 1'h0, 32'hffffffff, 32'h0, 6'h0, 3'h5);
    op(USR_OP_SUBFC, 1'h1, 32'h1, 32'h0, 6'h0, 3'h4);
    op(USR_OP_SRA, 1'h0, 32'h80000001, 32'h0, 6'h1, 3'h5);
    op(USR_OP_SRA, 1'h0, 32'h00000003, 32'h0, 6'h1, 3'h4);
    op(USR_OP_SRA, 1'h0, 32'h80000001, 32'h0, 6'h1, 3'h5);
    op(USR_OP_ADDE, 1'h1, 32'h7fffffff, 32'h0, 6'h0, 3'h6);
    op(USR_OP_SUBFE, 1'h0, 32'h0, 32'h1, 6'h0, 3'h7);
    op(USR_OP_SRA, 1'h0, 32'h80000000, 32'h0, 6'h1, 3'h6);
    // software clear and an overflow in one cycle: the set wins
    fork
      u_exec.alu(USR_OP_ADD, 1'h1, 32'h7fffffff, 32'h1, 6'h0);
      wr(USR_SPR_FLAGS, 32'h00000025, 1'h0, 1'h0);
    join
    rd(USR_SPR_FLAGS, 32'hc0000025, 1'h0);
    // branches: link written only with the link option, count wraps from zero
    wr(USR_SPR_COUNT, 32'h0, 1'h0, 1'h0);
    u_exec.br(1'h1, 1'h1, 32'h1003);
    rd(USR_SPR_LINK, 32'h1003, 1'h0);
    check("link fetch", {2'h0, linkFetchAddr}, 34'h1000);
    rd(USR_SPR_COUNT, 32'hffffffff, 1'h0);
    check("count target", {2'h0, countTarget}, 34'hffffffff);
    u_exec.br(1'h0, 1'h1, 32'h2000);
    rd(USR_SPR_LINK, 32'h1003, 1'h0);
    check("count target", {2'h0, countTarget}, 34'hfffffffe);
    wr(USR_SPR_LINK, 32'h12345677, 1'h0, 1'h0);
    rd(USR_SPR_LINK, 32'h12345677, 1'h0);
    check("link fetch", {2'h0, linkFetchAddr}, 34'h12345674);
    // time counter: refused writes, supervisor load, carry across halves
    wr(USR_SPR_TLO_RD, 32'h1, 1'h1, 1'h1);
    wr(USR_SPR_TLO_WR, 32'h1, 1'h0, 1'h1);
    wr(USR_SPR_TLO_WR, 32'hfffffffe, 1'h1, 1'h0);
    wr(USR_SPR_THI_WR, 32'h5, 1'h1, 1'h0);
    rd(USR_SPR_THI_RD, 32'h5, 1'h0);
    rd(USR_SPR_TLO_RD, 32'hfffffffe, 1'h0);
    u_exec.tick();
    u_exec.tick();
    // high, low, high again as software does for a coherent value
    rd(USR_SPR_THI_RD, 32'h6, 1'h0);
    rd(USR_SPR_TLO_RD, 32'h0, 1'h0);
    rd(USR_SPR_THI_RD, 32'h6, 1'h0);
    rd(10'h3ff, 32'h0, 1'h1);
    // mid-run reset leaves every register as it was
    reset = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    rd(USR_SPR_LINK, 32'h12345677, 1'h0);
    rd(USR_SPR_COUNT, 32'hfffffffe, 1'h0);
    rd(USR_SPR_FLAGS, 32'hc0000025, 1'h0);
    rd(USR_SPR_THI_RD, 32'h6, 1'h0);
    rd(USR_SPR_TLO_RD, 32'h0, 1'h0);
    close_out();
  end
endmodule : testbench
`default_nettype wire
